// ### src/sfl_front.sv
`timescale 1ns/1ps
module sfl_front import sfl_pkg::*; #(
  parameter int SW_CYCLES = STATUS_WRITE_CYCLES,
  parameter logic [7:0] MAKER_ID = MAKER_ID_DEFAULT,
  parameter logic [7:0] MEM_TYPE_ID = MEM_TYPE_ID_DEFAULT,
  parameter logic [7:0] PART_ID = PART_ID_DEFAULT
) (
  input wire logic clk, // System clock, 250 MHz
  input wire logic reset, // Synchronous reset, high
  input wire logic cs_n_pin, // Chip select, low active
  input wire logic sclk_pin, // Serial clock from host
  input wire logic si_pin, // Serial data in
  input wire logic io_line_two, // Write protect pin, low active
  input wire logic [NV_BITS-1:0] nv_stored, // Retained bits 7..2
  input wire logic op_busy, // Program/erase array busy
  input wire logic op_done, // Program/erase completed pulse
  output logic so, // Serial data out
  output logic so_oe, // Serial out drive enable
  output logic [7:0] status_flags, // Status register image
  output logic chip_erase_allowed, // Protect level is zero
  output logic hw_protect // Hardware protection active
);

  localparam int CW = $clog2(SW_CYCLES + 1);

  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  if (SW_CYCLES < 1) begin : g_bad_cycles
    $error("SW_CYCLES must be at least one");
  end

  typedef struct packed {
    sfl_state_t state;
    sfl_src_t src;
    logic [2:0] bitcnt;
    logic [1:0] bytecnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [2:0] outcnt;
    logic [1:0] out_idx;
    logic mp_part_first;
    logic [7:0] wdata;
    logic [NV_BITS-1:0] sw_data;
    logic sw_active;
    logic [CW-1:0] sw_count;
    logic [NV_BITS-1:0] nv;
    logic nv_loaded;
    logic write_latch_flag;
    logic busy;
    logic ce_ok;
    logic hwp;
    logic sclk_d;
    logic cs_d;
    logic so;
    logic so_oe;
  } sfl_regs_t;

  sfl_regs_t r;
  sfl_regs_t next_r;
  logic [3:0] pins_s;
  logic cs_n_s;
  logic sclk_s;
  logic si_s;
  logic wp_n_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic [7:0] rx_byte;
  logic byte_done;
  logic hw_now;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  sfl_sync #(
    .WIDTH(4),
    .RESET_VAL(4'h9)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .din({cs_n_pin, sclk_pin, si_pin, io_line_two}),
    .dout(pins_s)
  );

  assign cs_n_s = pins_s[3];
  assign sclk_s = pins_s[2];
  assign si_s = pins_s[1];
  assign wp_n_s = pins_s[0];

  assign sclk_rise = sclk_s & ~r.sclk_d;
  assign sclk_fall = ~sclk_s & r.sclk_d;
  assign cs_rise = cs_n_s & ~r.cs_d;
  assign rx_byte = {r.rx[6:0], si_s};
  assign byte_done = sclk_rise && (r.bitcnt == 3'h7);
  // Quad mode hands the protect pin over to data
  assign hw_now = r.nv[LOCK_BIT-NV_LO] & ~wp_n_s
                  & ~r.nv[QUAD_BIT-NV_LO];

  // ------------------------------------------------------------
  // Output byte selection
  // ------------------------------------------------------------
  function automatic logic [7:0] out_byte(
    input sfl_src_t src,
    input logic [1:0] idx,
    input logic part_first,
    input logic [7:0] stat
  );
    logic [7:0] b;
    b = stat;
    case (src)
      SRC_IDENT: begin
        case (idx)
          2'h0: b = MAKER_ID;
          2'h1: b = MEM_TYPE_ID;
          default: b = PART_ID;
        endcase
      end
      SRC_MAKER_PART: begin
        b = (idx[0] ^ part_first) ? PART_ID : MAKER_ID;
      end
      default: b = stat;
    endcase
    return b;
  endfunction

  function automatic logic [1:0] next_idx(
    input sfl_src_t src,
    input logic [1:0] idx
  );
    logic [1:0] n;
    n = 2'h0;
    case (src)
      SRC_IDENT: n = (idx == 2'h2) ? 2'h0 : idx + 2'h1;
      SRC_MAKER_PART: n = {1'b0, ~idx[0]};
      default: n = 2'h0;
    endcase
    return n;
  endfunction

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.sclk_d = sclk_s;
    next_r.cs_d = cs_n_s;

    // Retained bits come back from the store after power-up
    if (!r.nv_loaded) begin
      next_r.nv = nv_stored;
      next_r.nv_loaded = 1'b1;
    end

    // Array completions clear the latch; a refused protected
    // write never pulses op_done, so the latch stays put
    if (op_done) begin
      next_r.write_latch_flag = 1'b0;
    end

    // Self-timed status write
    if (r.sw_active) begin
      if (r.sw_count == CW'(SW_CYCLES - 1)) begin
        next_r.sw_active = 1'b0;
        next_r.sw_count = '0;
        next_r.nv = r.sw_data;
        next_r.write_latch_flag = 1'b0;
      end else begin
        next_r.sw_count = r.sw_count + CW'(1);
      end
    end

    if (cs_n_s) begin
      // Deselected: standby, abort any partial command
      next_r.state = ST_IDLE;
      next_r.bitcnt = 3'h0;
      next_r.so_oe = 1'b0;
      if (cs_rise) begin
        case (r.state)
          ST_LATCH_SET: next_r.write_latch_flag = 1'b1;
          ST_LATCH_CLR: next_r.write_latch_flag = 1'b0;
          ST_WDONE: begin
            if (r.write_latch_flag && !r.busy && !hw_now) begin
              next_r.sw_active = 1'b1;
              next_r.sw_count = '0;
              next_r.sw_data = r.wdata[7:NV_LO];
            end
          end
          default: ;
        endcase
      end
    end else begin
      if (r.state == ST_IDLE) begin
        next_r.state = ST_OPCODE;
      end
      if (sclk_rise) begin
        case (r.state)
          ST_IDLE, ST_OPCODE, ST_ADDR, ST_WDATA: begin
            next_r.rx = rx_byte;
            next_r.bitcnt = r.bitcnt + 3'h1;
          end
          // Extra clocks break the byte boundary
          ST_LATCH_SET, ST_LATCH_CLR, ST_WDONE: begin
            next_r.state = ST_IGNORE;
          end
          default: ;
        endcase
      end
      if (byte_done) begin
        case (r.state)
          ST_IDLE, ST_OPCODE: begin
            next_r.tx = out_byte(SRC_STATUS, 2'h0, 1'b0,
                                 {r.nv, r.write_latch_flag, r.busy});
            next_r.outcnt = 3'h0;
            next_r.out_idx = 2'h0;
            next_r.bytecnt = 2'h0;
            case (rx_byte)
              OP_SET_LATCH: next_r.state = ST_LATCH_SET;
              OP_CLEAR_LATCH: next_r.state = ST_LATCH_CLR;
              OP_WRITE_STATUS: next_r.state = ST_WDATA;
              OP_READ_STATUS: begin
                next_r.state = ST_SEND;
                next_r.src = SRC_STATUS;
              end
              OP_READ_IDENTITY: begin
                if (r.busy) begin
                  next_r.state = ST_IGNORE;
                end else begin
                  next_r.state = ST_SEND;
                  next_r.src = SRC_IDENT;
                  next_r.tx = MAKER_ID;
                end
              end
              OP_READ_MAKER_PART: begin
                next_r.state = r.busy ? ST_IGNORE : ST_ADDR;
              end
              default: next_r.state = ST_IGNORE;
            endcase
          end
          ST_ADDR: begin
            next_r.bytecnt = r.bytecnt + 2'h1;
            if (r.bytecnt == MAKER_PART_ADDR_BYTES - 2'h1) begin
              next_r.state = ST_SEND;
              next_r.src = SRC_MAKER_PART;
              next_r.mp_part_first = rx_byte[0];
              next_r.tx = out_byte(SRC_MAKER_PART, 2'h0, rx_byte[0],
                                   8'h00);
            end
          end
          ST_WDATA: begin
            next_r.wdata = rx_byte;
            next_r.state = ST_WDONE;
          end
          default: ;
        endcase
      end

      // Data leaves on falling edges, MSB first
      if (sclk_fall && r.state == ST_SEND) begin
        next_r.so = r.tx[7];
        next_r.so_oe = 1'b1;
        next_r.tx = {r.tx[6:0], 1'b0};
        next_r.outcnt = r.outcnt + 3'h1;
        if (r.outcnt == 3'h7) begin
          next_r.out_idx = next_idx(r.src, r.out_idx);
          next_r.tx = out_byte(r.src, next_idx(r.src, r.out_idx),
                               r.mp_part_first,
                               {r.nv, r.write_latch_flag, r.busy});
        end
      end
    end

    next_r.busy = op_busy | next_r.sw_active;
    next_r.ce_ok = (next_r.nv[PROTECT_HI-NV_LO:0] == 4'h0);
    next_r.hwp = hw_now;
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
      r.state <= ST_IDLE;
      r.src <= SRC_STATUS;
      r.nv <= NV_RESET;
      r.write_latch_flag <= 1'b0;
      r.cs_d <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign so = r.so;
  assign so_oe = r.so_oe;
  assign status_flags = {r.nv, r.write_latch_flag, r.busy};
  assign chip_erase_allowed = r.ce_ok;
  assign hw_protect = r.hwp;

endmodule

// ### src/sfl_pkg.sv
// Summary of operation
// - Latch-set opcode framed by select sets latch
// - Latch-clear opcode framed by select clears latch
// - Latch cleared at power-up and write completions
// - Identity command shifts out three ID bytes
// - Identity command not decoded while device busy
// - Select high after readout returns to standby
// - Status read always accepted, byte repeats continuously
// - Status bit 0 shows busy write cycle
// - Status bit 1 latch gates write commands
// - Protected-area write ignored, latch kept unchanged
// - Bits 5..2 protect level, status write only
// - Chip erase only when protect level zero
// - Bit 6 selects quad lines over write protect
// - Lock bit with protect pin low refuses writes
// - Bits 7..2 retained, bits 1..0 volatile
// - Maker/part read: address 00 maker first, 01 part
// - Status write sets busy, and its completion clears the latch
package sfl_pkg;

  // ------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
  localparam logic [7:0] OP_READ_IDENTITY = 8'h9F;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_MAKER_PART = 8'h90;

  // ------------------------------------------------------------
  // Status register layout
  // ------------------------------------------------------------
  localparam int BUSY_BIT = 0;
  localparam int LATCH_BIT = 1;
  localparam int PROTECT_LO = 2;
  localparam int PROTECT_HI = 5;
  localparam int QUAD_BIT = 6;
  localparam int LOCK_BIT = 7;
  localparam int NV_LO = 2;
  localparam int NV_BITS = 6;
  localparam logic [NV_BITS-1:0] NV_RESET = 6'h00;
  localparam logic [1:0] MAKER_PART_ADDR_BYTES = 2'h3;

  // ------------------------------------------------------------
  // Identity defaults, arbitrary neutral values
  // ------------------------------------------------------------
  localparam logic [7:0] MAKER_ID_DEFAULT = 8'hA5;
  localparam logic [7:0] MEM_TYPE_ID_DEFAULT = 8'h3C;
  localparam logic [7:0] PART_ID_DEFAULT = 8'h17;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int STATUS_WRITE_NS = 40000;
  localparam int STATUS_WRITE_CYCLES =
    (STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPCODE, ST_LATCH_SET, ST_LATCH_CLR, ST_ADDR,
    ST_WDATA, ST_WDONE, ST_SEND, ST_IGNORE
  } sfl_state_t;

  typedef enum logic [1:0] {
    SRC_STATUS, SRC_IDENT, SRC_MAKER_PART
  } sfl_src_t;

endpackage

// ### src/sfl_sync.sv
`timescale 1ns/1ps
module sfl_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous reset, high
  input wire logic [WIDTH-1:0] din, // Asynchronous pin levels
  output logic [WIDTH-1:0] dout // Synchronised levels
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// ### tb/sfl_front_checker.sv
`timescale 1ns/1ps
module sfl_front_checker import sfl_pkg::*; (
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic cs_n_pin, // Select
  input wire logic sclk_pin, // Link clock
  input wire logic si_pin, // Data in
  input wire logic io_line_two, // Protect pin
  input wire logic [NV_BITS-1:0] nv_stored, // Stored bits
  input wire logic op_busy, // Array busy
  input wire logic op_done, // Array done
  input wire logic so, // Data out
  input wire logic so_oe, // Out enable
  input wire logic [7:0] status_flags, // Status
  input wire logic chip_erase_allowed, // Erase gate
  input wire logic hw_protect // Lock state
);
  logic [3:0] hi_cnt;
  // Select-high age, so a late latch set is not taken for a fault
  always_ff @(posedge clk) begin
    if (reset || !cs_n_pin) begin
      hi_cnt <= 4'h0;
    end else if (hi_cnt != 4'hF) begin
      hi_cnt <= hi_cnt + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_ce_on;
    (status_flags[5:2] == 4'h0) [*3] |-> chip_erase_allowed;
  endproperty
  a_ce_on: assert property (p_ce_on) else $error("erase gate low");
  property p_ce_off;
    (status_flags[5:2] != 4'h0) [*2] |-> !chip_erase_allowed;
  endproperty
  a_ce_off: assert property (p_ce_off)
    else $error("erase gate high");
  property p_hwp_on;
    (status_flags[7] && !status_flags[6] && !io_line_two) [*5] |-> hw_protect;
  endproperty
  a_hwp_on: assert property (p_hwp_on) else $error("lock missing");
  property p_hwp_off;
    !status_flags[7] [*2] |-> !hw_protect;
  endproperty
  a_hwp_off: assert property (p_hwp_off) else $error("false lock");
  property p_done_clr;
    op_done && hi_cnt > 4'h8 |-> ##[1:2] !status_flags[1];
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("latch kept");
  property p_busy;
    op_busy [*3] |-> status_flags[0];
  endproperty
  a_busy: assert property (p_busy) else $error("busy not shown");
  property p_oe_idle;
    cs_n_pin [*6] |-> !so_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("out driven idle");
  property p_nv_hold;
    $changed(status_flags[7:2]) |->
      $past(status_flags[0]) || $past(reset, 2) || $past(reset, 3);
  endproperty
  a_nv_hold: assert property (p_nv_hold) else $error("bits moved");
  property p_sw_end;
    $fell(status_flags[0]) && !$past(op_busy) && !$past(op_busy, 2)
      |-> !status_flags[1];
  endproperty
  a_sw_end: assert property (p_sw_end)
    else $error("latch after write");
  c_set: cover property ($rose(status_flags[1]));
  c_lock: cover property ($rose(hw_protect));
  c_done: cover property ($fell(status_flags[0]));
endmodule

bind sfl_front sfl_front_checker chk_i (.clk(clk), .reset(reset),
  .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .si_pin(si_pin),
  .io_line_two(io_line_two), .nv_stored(nv_stored), .op_busy(op_busy),
  .op_done(op_done), .so(so), .so_oe(so_oe), .status_flags(status_flags),
  .chip_erase_allowed(chip_erase_allowed), .hw_protect(hw_protect));

// ### tb/sfl_front_tb_top.sv
`timescale 1ns/1ps
module sfl_front_tb_top import sfl_pkg::*;;
  typedef struct {
    logic [31:0] d;
    int nb;
    int nr;
    logic [31:0] e;
  } sfl_row_t;
  localparam logic [7:0] MK = MAKER_ID_DEFAULT;
  localparam logic [7:0] TY = MEM_TYPE_ID_DEFAULT;
  localparam logic [7:0] PT = PART_ID_DEFAULT;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic io_line_two = 1'b1;
  logic op_busy = 1'b0;
  logic op_done = 1'b0;
  int oe_cnt = 0;
  int oe_base = 0;
  logic cs_n, sclk, si, so, so_oe, chip_erase_allowed, hw_protect;
  logic [7:0] status_flags;
  logic [31:0] r;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  sfl_row_t rows [16];
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (so_oe) begin
      oe_cnt <= oe_cnt + 1;
    end
  end
  sfl_host host (.clk(clk), .so(so), .cs_n(cs_n), .sclk(sclk), .si(si));
  sfl_front #(.SW_CYCLES(200)) DUT (.clk(clk), .reset(reset),
    .cs_n_pin(cs_n), .sclk_pin(sclk), .si_pin(si),
    .io_line_two(io_line_two), .nv_stored(6'h04), .op_busy(op_busy),
    .op_done(op_done), .so(so), .so_oe(so_oe), .status_flags(status_flags),
    .chip_erase_allowed(chip_erase_allowed), .hw_protect(hw_protect));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
      input string name);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Ceiling is about four times the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    rows = '{'{32'h05, 8, 8, 32'h10}, '{32'h03, 7, 0, 32'h0},
      '{32'h05, 8, 8, 32'h10}, '{32'h06, 8, 0, 32'h0},
      '{32'h05, 8, 16, 32'h1212}, '{32'h04, 8, 0, 32'h0},
      '{32'h05, 8, 8, 32'h10}, '{32'h9F, 8, 32, {MK, TY, PT, MK}},
      '{32'h90000000, 32, 16, {16'h0000, MK, PT}},
      '{32'h90000001, 32, 16, {16'h0000, PT, MK}},
      '{32'h01FF, 16, 0, 32'h0}, '{32'h05, 8, 8, 32'h10},
      '{32'h06, 8, 0, 32'h0}, '{32'h0183, 16, 0, 32'h0},
      '{32'h05, 8, 8, 32'h13}, '{32'h05, 8, 8, 32'h80}};
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    chk(chip_erase_allowed, 32'h0, "erase gate");
    for (int i = 0; i < 16; i++) begin
      host.frame(rows[i].d, rows[i].nb, rows[i].nr, r);
      if (rows[i].nr > 0) begin
        chk(r, rows[i].e, $sformatf("row %0d", i));
      end
    end
    chk(chip_erase_allowed, 32'h1, "erase gate");
    io_line_two = 1'b0;
    host.frame(32'h06, 8, 0, r);
    host.frame(32'h0100, 16, 0, r);
    host.frame(32'h05, 8, 8, r);
    chk(r, 32'h82, "locked status");
    chk(hw_protect, 32'h1, "lock state");
    io_line_two = 1'b1;
    op_busy = 1'b1;
    oe_base = oe_cnt;
    host.frame(32'h9F, 8, 8, r);
    chk(32'(oe_cnt - oe_base), 32'h0, "identity while busy");
    host.frame(32'h05, 8, 8, r);
    chk(r, 32'h83, "busy status");
    // Long idle select so the checker's latch-clear check is armed
    repeat (12) @(negedge clk);
    op_done = 1'b1;
    op_busy = 1'b0;
    @(negedge clk);
    op_done = 1'b0;
    host.frame(32'h05, 8, 8, r);
    chk(r, 32'h80, "status after done");
    reset = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    chk(status_flags, 32'h10, "status after reset");
    chk(chip_erase_allowed, 32'h0, "erase gate");
    give_verdict();
  end
endmodule

// ### tb/sfl_host.sv
`timescale 1ns/1ps
module sfl_host (
  input wire logic clk, // System clock
  input wire logic so, // Data from device
  output logic cs_n, // Select
  output logic sclk, // Link clock
  output logic si // Data to device
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  task automatic half();
    repeat (6) @(negedge clk);
  endtask
  // Clock parks low between frames; bits go MSB first
  task automatic frame(input logic [31:0] d, input int nb, input int nr,
      output logic [31:0] r);
    r = '0;
    cs_n = 1'b0;
    half();
    for (int i = nb - 1; i >= 0; i--) begin
      si = d[i];
      half();
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    for (int i = 0; i < nr; i++) begin
      si = ~si;
      half();
      r = {r[30:0], so};
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    si = ~si;
    half();
  endtask
endmodule
